// [logic/lane_write_pkg.sv]
// shared types and constants for the byte lane write suppress block
// assumes a single 200 MHz clock and synchronous inputs
package lane_write_pkg;

  localparam int unsigned LANES = 4;

  // transfer size option codes
  localparam logic [1:0] SIZE_WORD = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_HALF = 2'h2;

  // byte order: 0 big, 1 little
  localparam logic ORDER_BIG    = 1'h0;
  localparam logic ORDER_LITTLE = 1'h1;

  // reset values and lane select masks
  localparam logic       ORDER_RST  = 1'h0;
  localparam logic [3:0] STROBE_RST = 4'hf;
  localparam logic [3:0] LANE_ALL   = 4'hf;
  localparam logic [3:0] LANE_ONE   = 4'h1;
  localparam logic [3:0] HALF_UPPER = 4'hc;
  localparam logic [3:0] HALF_LOWER = 4'h3;

  // fixed ordering build: decode uses only one ordering
  localparam logic ORDER_FIXED_EN  = 1'h0;
  localparam logic ORDER_FIXED_VAL = 1'h0;

  // memory technology of the array
  typedef enum logic [4:0] {
    MEM_SRAM_OE   = 5'h01,
    MEM_SRAM_NOOE = 5'h02,
    MEM_VDRAM     = 5'h04,
    MEM_DRAM_X1   = 5'h08,
    MEM_DRAM_X4   = 5'h10
  } mem_type_e;

  // how a blocked lane is kept from writing
  typedef enum logic [2:0] {
    BLK_CANCEL  = 3'h1,
    BLK_REFRESH = 3'h2,
    BLK_IREAD   = 3'h4
  } blk_method_e;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [1:0] size;
    logic [1:0] addr;
  } mem_req_s;

  typedef struct packed {
    logic cyc;
    logic ras;
    logic cas;
    logic we;
    logic oe;
  } mem_timing_s;

  typedef struct packed {
    logic [3:0] cs_n;
    logic [3:0] ras_n;
    logic [3:0] cas_n;
    logic [3:0] we_n;
    logic [3:0] oe_n;
  } lane_ctl_s;

  localparam lane_ctl_s CTL_RST = '{
    cs_n:  4'hf,
    ras_n: 4'hf,
    cas_n: 4'hf,
    we_n:  4'hf,
    oe_n:  4'hf
  };

endpackage : lane_write_pkg

// [logic/byte_lane_write_suppress.sv]
// per byte lane strobes and write suppression for a 32-bit memory
// assumes timing windows come from the memory controller sequencer
// and that all inputs are synchronous to clk_i
// en_i low freezes every flop, outputs included
`timescale 1ns/10ps

//
// Contract
// - block any lanes while others write
// - separate control per byte lane
// - blocked lane cancelled or made non-write
// - no driving read on shared bus
// - sram oe: withhold cs, or we+oe
// - never cs with oe blocked store
// - sram without oe: withhold cs
// - vdram: withhold ras, cas, or we+oe
// - vdram prefers withholding cas
// - byte order xors low address bits
// - byte order kept in external copy
// - fixed ordering may drop other terms
// - x1 dram: withhold ras or cas
// - x4 dram handled like vdram
// - size codes word byte half
// - strobes only inside cas window
// - lanes chosen from size and address
module byte_lane_write_suppress (
  // clock, reset, enable
  input  wire logic                       clk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       en_i,
  // processor access
  input  wire lane_write_pkg::mem_req_s   req_i,
  // byte order copy update
  input  wire logic                       order_wr_i,
  input  wire logic                       byte_order_select_i,
  // memory configuration
  input  wire lane_write_pkg::mem_type_e  mem_type_i,
  input  wire lane_write_pkg::blk_method_e blk_method_i,
  // sequencer timing windows
  input  wire lane_write_pkg::mem_timing_s timing_i,
  // lane strobes, active low
  output logic [3:0]                      lane_strobe_n_o,
  // per lane memory controls, active low
  output lane_write_pkg::lane_ctl_s       lane_ctl_o,
  // current byte order copy
  output logic                            byte_order_o
);

  logic                      order_q;
  logic                      order_d;
  logic                      order_eff;
  logic [1:0]                lane_ptr;
  logic [3:0]                sel_d;
  logic                      store;
  logic [3:0]                strobe_n_q;
  logic [3:0]                strobe_n_d;
  logic [3:0]                cs_n_q;
  logic [3:0]                ras_n_q;
  logic [3:0]                cas_n_q;
  logic [3:0]                we_n_q;
  logic [3:0]                oe_n_q;
  lane_write_pkg::lane_ctl_s ctl_d;

  // next order copy on a write
  always_comb begin
    order_d = order_q;
    if (order_wr_i) begin
      order_d = byte_order_select_i;
    end
  end

  // register copy of the order bit
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      order_q <= lane_write_pkg::ORDER_RST;
    end else if (en_i) begin
      order_q <= order_d;
    end
  end

  always_comb begin
    if (lane_write_pkg::ORDER_FIXED_EN) begin
      order_eff = lane_write_pkg::ORDER_FIXED_VAL;
    end else begin
      order_eff = order_q;
    end
  end

  always_comb begin
    lane_ptr = req_i.addr ^ {~order_eff, ~order_eff};
  end

  always_comb begin
    store = req_i.valid & req_i.write;
  end

  // lanes from size, address and byte order
  always_comb begin
    sel_d = lane_write_pkg::LANE_ALL;
    if (store) begin
      case (req_i.size)
        lane_write_pkg::SIZE_BYTE: begin
          sel_d = lane_write_pkg::LANE_ONE << lane_ptr;
        end
        lane_write_pkg::SIZE_HALF: begin
          if (lane_ptr[1]) begin
            sel_d = lane_write_pkg::HALF_UPPER;
          end else begin
            sel_d = lane_write_pkg::HALF_LOWER;
          end
        end
        // word and reserved code write all
        default: begin
          sel_d = lane_write_pkg::LANE_ALL;
        end
      endcase
    end
  end

  for (genvar i = 0; i < lane_write_pkg::LANES; i++) begin : g_lane
    logic blk;
    logic kill_cs;
    logic kill_ras;
    logic kill_cas;
    logic kill_we;
    logic kill_oe;

    // only unselected lanes of a store
    always_comb begin
      blk = store & ~sel_d[i];
    end

    always_comb begin
      kill_cs  = 1'b0;
      kill_ras = 1'b0;
      kill_cas = 1'b0;
      kill_we  = 1'b0;
      kill_oe  = 1'b0;
      case (mem_type_i)
        lane_write_pkg::MEM_SRAM_OE: begin
          case (blk_method_i)
            // internal read, data pins stay quiet
            lane_write_pkg::BLK_IREAD: begin
              kill_we = blk;
              kill_oe = blk;
            end
            // no refresh cycle on sram, so cancel
            default: begin
              kill_cs = blk;
            end
          endcase
        end
        lane_write_pkg::MEM_SRAM_NOOE: begin
          kill_cs = blk;
        end
        // no internal read on x1 parts
        lane_write_pkg::MEM_DRAM_X1: begin
          case (blk_method_i)
            lane_write_pkg::BLK_CANCEL: begin
              kill_ras = blk;
            end
            // ras only refresh, iread falls here too
            default: begin
              kill_cas = blk;
            end
          endcase
        end
        lane_write_pkg::MEM_VDRAM,
        lane_write_pkg::MEM_DRAM_X4: begin
          case (blk_method_i)
            lane_write_pkg::BLK_CANCEL: begin
              kill_ras = blk;
            end
            lane_write_pkg::BLK_IREAD: begin
              kill_we = blk;
              kill_oe = blk;
            end
            default: begin
              kill_cas = blk;
            end
          endcase
        end
        // unknown type: block the whole lane cycle
        default: begin
          kill_cs  = blk;
          kill_ras = blk;
        end
      endcase
    end

    always_comb begin
      ctl_d.cs_n[i] = ~(timing_i.cyc & req_i.valid & ~kill_cs);
    end

    always_comb begin
      ctl_d.ras_n[i] = ~(timing_i.ras & req_i.valid & ~kill_ras);
    end

    always_comb begin
      ctl_d.cas_n[i] = ~(timing_i.cas & req_i.valid & ~kill_cas);
    end

    // write enable on stores only
    // loads never raise it, so a read cannot corrupt
    always_comb begin
      ctl_d.we_n[i] = ~(timing_i.we & store & ~kill_we);
    end

    // so a store never pairs cs with oe
    always_comb begin
      ctl_d.oe_n[i] = ~(timing_i.oe & req_i.valid & ~req_i.write & ~kill_oe);
    end

    always_comb begin
      strobe_n_d[i] = ~(sel_d[i] & timing_i.cas & req_i.valid);
    end
  end

  // strobes gated by the cas window
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      strobe_n_q <= lane_write_pkg::STROBE_RST;
    end else if (en_i) begin
      strobe_n_q <= strobe_n_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cs_n_q <= lane_write_pkg::CTL_RST.cs_n;
    end else if (en_i) begin
      cs_n_q <= ctl_d.cs_n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ras_n_q <= lane_write_pkg::CTL_RST.ras_n;
    end else if (en_i) begin
      ras_n_q <= ctl_d.ras_n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cas_n_q <= lane_write_pkg::CTL_RST.cas_n;
    end else if (en_i) begin
      cas_n_q <= ctl_d.cas_n;
    end
  end

  // registered write enables
  // held high in reset so no stray write
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      we_n_q <= lane_write_pkg::CTL_RST.we_n;
    end else if (en_i) begin
      we_n_q <= ctl_d.we_n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      oe_n_q <= lane_write_pkg::CTL_RST.oe_n;
    end else if (en_i) begin
      oe_n_q <= ctl_d.oe_n;
    end
  end

  // outputs straight from flip-flops
  always_comb begin
    lane_strobe_n_o = strobe_n_q;
  end

  // per lane controls to the array
  always_comb begin
    lane_ctl_o.cs_n  = cs_n_q;
    lane_ctl_o.ras_n = ras_n_q;
    lane_ctl_o.cas_n = cas_n_q;
    lane_ctl_o.we_n  = we_n_q;
    lane_ctl_o.oe_n  = oe_n_q;
  end

  always_comb begin
    byte_order_o = order_q;
  end

endmodule : byte_lane_write_suppress

// [dv/lane_write_props.sv]
// lane strobe and control assertions
// assumes a bind onto the block top
`timescale 1ns/10ps
module lane_write_props (
  // block ports
  input wire logic                        clk_i,
  input wire logic                        rstn_i,
  input wire logic                        en_i,
  input wire lane_write_pkg::mem_req_s    req_i,
  input wire logic                        order_wr_i,
  input wire logic                        byte_order_select_i,
  input wire lane_write_pkg::mem_type_e   mem_type_i,
  input wire lane_write_pkg::blk_method_e blk_method_i,
  input wire lane_write_pkg::mem_timing_s timing_i,
  input wire logic [3:0]                  lane_strobe_n_o,
  input wire lane_write_pkg::lane_ctl_s   lane_ctl_o,
  input wire logic                        byte_order_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic st;
  assign st = en_i && req_i.valid && req_i.write && timing_i.cas;
  property p_order; en_i && order_wr_i |=> byte_order_o == $past(byte_order_select_i); endproperty
  a_order: assert property (p_order) else $error("order copy");
  property p_gate; en_i && !timing_i.cas |=> lane_strobe_n_o == 4'hf; endproperty
  a_gate: assert property (p_gate) else $error("strobe outside window");
  property p_word; st && req_i.size == 2'h0 |=> lane_strobe_n_o == 4'h0; endproperty
  a_word: assert property (p_word) else $error("word lanes");
  property p_byte; st && req_i.size == 2'h1 |=> $countones(~lane_strobe_n_o) == 1; endproperty
  a_byte: assert property (p_byte) else $error("byte lanes");
  property p_half; st && req_i.size == 2'h2 |=> lane_strobe_n_o inside {4'h3, 4'hc}; endproperty
  a_half: assert property (p_half) else $error("half lanes");
  property p_oe; en_i && req_i.valid && req_i.write |=> lane_ctl_o.oe_n == 4'hf; endproperty
  a_oe: assert property (p_oe) else $error("oe in store");
  property p_cas;
    st && mem_type_i == lane_write_pkg::MEM_VDRAM && blk_method_i == lane_write_pkg::BLK_REFRESH
      |=> lane_ctl_o.cas_n == lane_strobe_n_o;
  endproperty
  a_cas: assert property (p_cas) else $error("cas withhold");
  property p_cs;
    st && timing_i.cyc && mem_type_i == lane_write_pkg::MEM_SRAM_NOOE |=> lane_ctl_o.cs_n == lane_strobe_n_o;
  endproperty
  a_cs: assert property (p_cs) else $error("cs withhold");
endmodule : lane_write_props

// [dv/cpu_master.sv]
// processor side master issuing stores and loads
// assumes calls are made from the bench
`timescale 1ns/10ps
module cpu_master (
  // clock
  input  wire logic                  clk_i,
  // access and timing
  output lane_write_pkg::mem_req_s    req_o,
  output lane_write_pkg::mem_timing_s timing_o
);
  initial begin
    req_o = '0;
    timing_o = '0;
  end
  task xfer(input logic w, input logic [1:0] s, input logic [1:0] a, input logic c);
    @(negedge clk_i);
    req_o = '{valid: 1'h1, write: w, size: s, addr: a};
    timing_o = '{cyc: 1'h1, ras: 1'h1, cas: c, we: w, oe: ~w};
  endtask : xfer
endmodule : cpu_master

// [dv/testbench.sv]
// top bench for the lane write suppress block
// assumes inputs change on the falling edge
`timescale 1ns/10ps
module testbench;
  logic clk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic en_i, order_wr_i, byte_order_select_i, byte_order_o;
  lane_write_pkg::mem_type_e   mem_type_i;
  lane_write_pkg::blk_method_e blk_method_i;
  lane_write_pkg::mem_req_s    req_i;
  lane_write_pkg::mem_timing_s timing_i;
  lane_write_pkg::lane_ctl_s   lane_ctl_o;
  logic [3:0] lane_strobe_n_o, e;
  int error_cnt = 0, tests_run = 0, cyc_cnt = 0;
  always #2.5 clk_i = ~clk_i;
  cpu_master u_cpu (.clk_i(clk_i), .req_o(req_i), .timing_o(timing_i));
  byte_lane_write_suppress u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .en_i(en_i), .req_i(req_i),
    .order_wr_i(order_wr_i), .byte_order_select_i(byte_order_select_i), .mem_type_i(mem_type_i),
    .blk_method_i(blk_method_i), .timing_i(timing_i), .lane_strobe_n_o(lane_strobe_n_o),
    .lane_ctl_o(lane_ctl_o), .byte_order_o(byte_order_o));
  task chk(input logic [3:0] g, input logic [3:0] x);
    tests_run++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task report_and_stop;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // active low lanes; loads and words take all
  function logic [3:0] exp_f(input logic w, input logic [1:0] s, a, input logic b);
    logic [1:0] p;
    p = a ^ {~b, ~b};
    if (!w || s == lane_write_pkg::SIZE_WORD || s == 2'h3) return 4'h0;
    if (s == lane_write_pkg::SIZE_BYTE) return ~(4'h1 << p);
    return p[1] ? 4'h3 : 4'hc;
  endfunction : exp_f
  task run(input logic w, input logic [1:0] s, a, input logic c);
    u_cpu.xfer(w, s, a, c);
    @(negedge clk_i);
  endtask : run
  initial begin
    en_i = 1'h1;
    order_wr_i = 1'h0;
    byte_order_select_i = 1'h0;
    mem_type_i = lane_write_pkg::MEM_VDRAM;
    blk_method_i = lane_write_pkg::BLK_REFRESH;
    repeat (8) @(negedge clk_i);
    rstn_i = 1'h1;
    chk(lane_strobe_n_o, 4'hf);
    for (int b = 0; b < 2; b++) begin
      order_wr_i = 1'h1;
      byte_order_select_i = b[0];
      @(negedge clk_i);
      order_wr_i = 1'h0;
      chk({3'h0, byte_order_o}, {3'h0, b[0]});
      for (int k = 0; k < 32; k++) begin
        e = exp_f(k[4], k[3:2], k[1:0], b[0]);
        run(k[4], k[3:2], k[1:0], 1'h1);
        chk(lane_strobe_n_o, e);
        chk(lane_ctl_o.cas_n, e);
        chk(lane_ctl_o.oe_n, k[4] ? 4'hf : 4'h0);
      end
    end
    run(1'h1, 2'h0, 2'h0, 1'h0);
    chk(lane_strobe_n_o, 4'hf);
    // little endian byte lands on lane 2
    mem_type_i = lane_write_pkg::MEM_SRAM_NOOE;
    blk_method_i = lane_write_pkg::BLK_CANCEL;
    run(1'h1, 2'h1, 2'h2, 1'h1);
    chk(lane_ctl_o.cs_n, 4'hb);
    mem_type_i = lane_write_pkg::MEM_DRAM_X1;
    run(1'h1, 2'h1, 2'h2, 1'h1);
    chk(lane_ctl_o.ras_n, 4'hb);
    mem_type_i = lane_write_pkg::MEM_SRAM_OE;
    blk_method_i = lane_write_pkg::BLK_IREAD;
    run(1'h1, 2'h1, 2'h2, 1'h1);
    chk(lane_ctl_o.we_n, 4'hb);
    chk(lane_ctl_o.oe_n, 4'hf);
    mem_type_i = lane_write_pkg::MEM_DRAM_X4;
    run(1'h1, 2'h1, 2'h2, 1'h1);
    chk(lane_ctl_o.we_n, 4'hb);
    mem_type_i = lane_write_pkg::MEM_SRAM_OE;
    blk_method_i = lane_write_pkg::BLK_CANCEL;
    run(1'h1, 2'h1, 2'h2, 1'h1);
    chk(lane_ctl_o.cs_n, 4'hb);
    mem_type_i = lane_write_pkg::MEM_VDRAM;
    run(1'h1, 2'h1, 2'h2, 1'h1);
    chk(lane_ctl_o.ras_n, 4'hb);
    blk_method_i = lane_write_pkg::BLK_IREAD;
    run(1'h1, 2'h1, 2'h2, 1'h1);
    chk(lane_ctl_o.we_n, 4'hb);
    chk(lane_ctl_o.oe_n, 4'hf);
    mem_type_i = lane_write_pkg::MEM_DRAM_X1;
    blk_method_i = lane_write_pkg::BLK_REFRESH;
    run(1'h1, 2'h1, 2'h2, 1'h1);
    chk(lane_ctl_o.cas_n, 4'hb);
    // unknown type cancels the whole lane
    mem_type_i = lane_write_pkg::mem_type_e'(5'h00);
    run(1'h1, 2'h1, 2'h2, 1'h1);
    chk(lane_ctl_o.cs_n, 4'hb);
    chk(lane_ctl_o.ras_n, 4'hb);
    // enable low holds every output
    en_i = 1'h0;
    run(1'h1, 2'h0, 2'h0, 1'h1);
    chk(lane_strobe_n_o, 4'hb);
    en_i = 1'h1;
    report_and_stop();
  end
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt > 1000) begin
      error_cnt++;
      report_and_stop();
    end
  end
endmodule : testbench
bind byte_lane_write_suppress lane_write_props u_props (.clk_i(clk_i), .rstn_i(rstn_i), .en_i(en_i),
  .req_i(req_i), .order_wr_i(order_wr_i), .byte_order_select_i(byte_order_select_i), .mem_type_i(mem_type_i),
  .blk_method_i(blk_method_i), .timing_i(timing_i), .lane_strobe_n_o(lane_strobe_n_o),
  .lane_ctl_o(lane_ctl_o), .byte_order_o(byte_order_o));
